// file: src/rdtq_alloc_regs.sv
// Purpose: Allocation control register bank of one logical processor.
// Assumes: Register reads and writes arrive as single-cycle requests, one at a time.
// Notes:   Each request is answered one cycle later with data or a protection fault.

// What this block does
// - Unsupported or bad register access faults with zero
// - Report general allocation support in leaf seven
// - Report allocation-capable resources in leaf sixteen
// - Report classes, mask length, delay, split per resource
// - Code/data split off until configuration enables it
// - One mask per class per cache, one throttle
// - Mask changes only shift capacity, never break function
// - Association register accessible any time, no sequencing
// - Thread class selects applied mask and throttle
// - I/O agent enable register at fixed address
// - Counters are 32 bits, width reported
// - Fifteen classes each for bandwidth and L3
// - Cache-heavy threads throttled less below threshold
// - Software selects min or max throttle resolution
// - L2 and L3 split enable independently
module rdtq_alloc_regs
	import rdtq_pkg::*;
(
	// Clock and reset.
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	// Model-specific register access.
	input  wire logic                 msr_rd_i,
	input  wire logic                 msr_wr_i,
	input  wire logic [31:0]          msr_addr_i,
	input  wire logic [63:0]          msr_wdata_i,
	output logic                      msr_ack_o,
	output logic      [63:0]          msr_rdata_o,
	output logic                      protection_fault_zero_o,
	// Identification query.
	input  wire logic                 id_req_i,
	input  wire logic [31:0]          id_leaf_i,
	input  wire logic [31:0]          id_subleaf_i,
	output logic                      id_ack_o,
	output logic      [31:0]          id_eax_o,
	output logic      [31:0]          id_ebx_o,
	output logic      [31:0]          id_ecx_o,
	output logic      [31:0]          id_edx_o,
	// Bandwidth feedback from the core.
	input  wire logic                 l3_hit_heavy_i,
	input  wire logic [BW_THR_W-1:0]  bw_usage_i,
	input  wire logic [THRTL_W-1:0]   sibling_throttle_i,
	// Settings applied to the thread's accesses.
	output logic      [CLS_W-1:0]     service_class_o,
	output logic      [MON_TAG_W-1:0] monitor_tag_id_o,
	output logic      [L3_MASK_LEN-1:0] l3_data_mask_o,
	output logic      [L3_MASK_LEN-1:0] l3_code_mask_o,
	output logic      [L2_MASK_LEN-1:0] l2_data_mask_o,
	output logic      [L2_MASK_LEN-1:0] l2_code_mask_o,
	output logic      [THRTL_W-1:0]   throttle_o,
	// Feature enables.
	output logic                      l3_code_data_split_o,
	output logic                      l2_code_data_split_o,
	output logic                      io_alloc_en_o,
	output logic                      io_mon_en_o
);

	// Configuration state.
	logic [1:0]             qos_cfg_q;
	logic [1:0]             io_qos_q;
	logic [BW_THR_W-1:0]    bw_thr_q;
	logic                   res_max_q;
	logic                   wc_en_q;
	logic [CLS_W-1:0]       assoc_cls_q;
	logic [MON_TAG_W-1:0]   assoc_tag_q;

	// Decode results.
	logic [31:0]            l3_off;
	logic [31:0]            l2_off;
	logic [31:0]            th_off;
	logic                   hit_qcfg;
	logic                   hit_ioq;
	logic                   hit_bwc;
	logic                   hit_assoc;
	logic                   hit_l3;
	logic                   hit_l2;
	logic                   hit_th;
	logic                   wr_bad;
	logic [CLS_W-1:0]       wr_cls;
	logic                   split_any;
	logic [63:0]            rdata_d;
	logic                   fault_d;

	// Table ports.
	logic [CLS_W-1:0]       tbl_idx;
	logic [CLS_W-1:0]       l3_d_idx;
	logic [CLS_W-1:0]       l3_c_idx;
	logic [CLS_W-1:0]       l2_d_idx;
	logic [CLS_W-1:0]       l2_c_idx;
	logic [L3_MASK_LEN-1:0] l3_rd;
	logic [L3_MASK_LEN-1:0] l3_a;
	logic [L3_MASK_LEN-1:0] l3_b;
	logic [L2_MASK_LEN-1:0] l2_rd;
	logic [L2_MASK_LEN-1:0] l2_a;
	logic [L2_MASK_LEN-1:0] l2_b;
	logic [THRTL_W-1:0]     th_rd;
	logic [THRTL_W-1:0]     th_a;
	logic [THRTL_W-1:0]     th_reduced;
	logic [THRTL_W-1:0]     th_resolved;

	// Address decode for the fixed registers and the per-class arrays.
	assign l3_off = msr_addr_i - ADDR_L3_MASK_BASE;
	assign l2_off = msr_addr_i - ADDR_L2_MASK_BASE;
	assign th_off = msr_addr_i - ADDR_THRTL_BASE;
	assign tbl_idx = hit_l3 ? l3_off[CLS_W-1:0] :
	                 hit_l2 ? l2_off[CLS_W-1:0] : th_off[CLS_W-1:0];
	assign wr_cls = msr_wdata_i[ASSOC_CLS_LSB +: CLS_W];
	assign split_any = qos_cfg_q[QCFG_L3_CDP_BIT] | qos_cfg_q[QCFG_L2_CDP_BIT];

	always_comb begin
		hit_qcfg  = 1'b0;
		hit_ioq   = 1'b0;
		hit_bwc   = 1'b0;
		hit_assoc = 1'b0;
		hit_l3    = 1'b0;
		hit_l2    = 1'b0;
		hit_th    = 1'b0;
		if (msr_addr_i == ADDR_QOS_CFG) begin
			hit_qcfg = SUP_L3 | SUP_L2;
		end else if (msr_addr_i == ADDR_IO_QOS) begin
			hit_ioq = SUP_L3;
		end else if (msr_addr_i == ADDR_BW_CFG) begin
			hit_bwc = SUP_BW;
		end else if (msr_addr_i == ADDR_ASSOC) begin
			hit_assoc = 1'b1;
		end else if (l3_off < 32'(NUM_CLASS)) begin
			hit_l3 = SUP_L3;
		end else if (l2_off < 32'(NUM_CLASS)) begin
			hit_l2 = SUP_L2;
		end else if (th_off < 32'(NUM_CLASS)) begin
			hit_th = SUP_BW;
		end
	end

	// Write values that touch reserved bits or exceed a limit are refused.
	always_comb begin
		wr_bad = 1'b0;
		if (hit_qcfg) begin
			wr_bad = |(msr_wdata_i & ~QCFG_MASK);
		end else if (hit_ioq) begin
			wr_bad = |(msr_wdata_i & ~IOQ_MASK);
		end else if (hit_bwc) begin
			wr_bad = |(msr_wdata_i & ~BWC_MASK);
		end else if (hit_assoc) begin
			// With a split active each class owns two mask entries, so fewer classes.
			wr_bad = (|(msr_wdata_i & ~ASSOC_MASK)) ||
			         (split_any ? (int'(wr_cls) >= NUM_CLASS_CDP)
			                    : (int'(wr_cls) >= NUM_CLASS));
		end else if (hit_l3) begin
			wr_bad = |(msr_wdata_i[63:L3_MASK_LEN]);
		end else if (hit_l2) begin
			wr_bad = |(msr_wdata_i[63:L2_MASK_LEN]);
		end else if (hit_th) begin
			wr_bad = (|msr_wdata_i[63:THRTL_W]) || (msr_wdata_i[THRTL_W-1:0] > MAX_DELAY);
		end
	end

	// Read data and fault for the current request.
	always_comb begin
		rdata_d = '0;
		fault_d = 1'b0;
		if (hit_qcfg) begin
			rdata_d[1:0] = qos_cfg_q;
		end else if (hit_ioq) begin
			rdata_d[1:0] = io_qos_q;
		end else if (hit_bwc) begin
			rdata_d[BW_THR_W-1:0]   = bw_thr_q;
			rdata_d[BWC_RES_MAX_BIT] = res_max_q;
			rdata_d[BWC_WC_EN_BIT]   = wc_en_q;
		end else if (hit_assoc) begin
			rdata_d[MON_TAG_W-1:0]            = assoc_tag_q;
			rdata_d[ASSOC_CLS_LSB +: CLS_W]   = assoc_cls_q;
		end else if (hit_l3) begin
			rdata_d[L3_MASK_LEN-1:0] = l3_rd;
		end else if (hit_l2) begin
			rdata_d[L2_MASK_LEN-1:0] = l2_rd;
		end else if (hit_th) begin
			rdata_d[THRTL_W-1:0] = th_rd;
		end else begin
			fault_d = 1'b1;
		end
		if (msr_wr_i && wr_bad) begin
			fault_d = 1'b1;
		end
	end

	// Answer registers; a faulting access returns zero data.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			msr_ack_o               <= 1'b0;
			msr_rdata_o             <= '0;
			protection_fault_zero_o <= 1'b0;
		end else begin
			msr_ack_o               <= msr_rd_i | msr_wr_i;
			protection_fault_zero_o <= (msr_rd_i | msr_wr_i) & fault_d;
			msr_rdata_o             <= (msr_rd_i && !fault_d) ? rdata_d : '0;
		end
	end

	// Code/data split enables, off from reset; each level is independent.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			qos_cfg_q <= '0;
		end else if (msr_wr_i && hit_qcfg && !wr_bad) begin
			qos_cfg_q <= msr_wdata_i[1:0];
		end
	end

	// Non-CPU agent features stay off until enabled here.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			io_qos_q <= '0;
		end else if (msr_wr_i && hit_ioq && !wr_bad) begin
			io_qos_q <= msr_wdata_i[1:0];
		end
	end

	// Bandwidth threshold, resolution choice and work-conserving enable.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			bw_thr_q  <= '0;
			res_max_q <= 1'b0;
			wc_en_q   <= 1'b0;
		end else if (msr_wr_i && hit_bwc && !wr_bad) begin
			bw_thr_q  <= msr_wdata_i[BW_THR_W-1:0];
			res_max_q <= msr_wdata_i[BWC_RES_MAX_BIT];
			wc_en_q   <= msr_wdata_i[BWC_WC_EN_BIT];
		end
	end

	// Thread association; takes effect on the next access, no flush is issued.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			assoc_cls_q <= '0;
			assoc_tag_q <= '0;
		end else if (msr_wr_i && hit_assoc && !wr_bad) begin
			assoc_cls_q <= wr_cls;
			assoc_tag_q <= msr_wdata_i[MON_TAG_W-1:0];
		end
	end

	// With a split, class n uses entry 2n for data and 2n+1 for code.
	assign l3_d_idx = qos_cfg_q[QCFG_L3_CDP_BIT] ? {assoc_cls_q[2:0], 1'b0} : assoc_cls_q;
	assign l3_c_idx = qos_cfg_q[QCFG_L3_CDP_BIT] ? {assoc_cls_q[2:0], 1'b1} : assoc_cls_q;
	assign l2_d_idx = qos_cfg_q[QCFG_L2_CDP_BIT] ? {assoc_cls_q[2:0], 1'b0} : assoc_cls_q;
	assign l2_c_idx = qos_cfg_q[QCFG_L2_CDP_BIT] ? {assoc_cls_q[2:0], 1'b1} : assoc_cls_q;

	// Masks reset to all ones so every class starts with the whole cache.
	rdtq_class_table #(
		.W       (L3_MASK_LEN),
		.RST_VAL ({L3_MASK_LEN{1'b1}})
	) u_l3_mask (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (msr_wr_i && hit_l3 && !wr_bad),
		.wr_idx_i  (tbl_idx),
		.wr_data_i (msr_wdata_i[L3_MASK_LEN-1:0]),
		.rd_idx_i  (tbl_idx),
		.rd_data_o (l3_rd),
		.a_idx_i   (l3_d_idx),
		.a_data_o  (l3_a),
		.b_idx_i   (l3_c_idx),
		.b_data_o  (l3_b)
	);

	rdtq_class_table #(
		.W       (L2_MASK_LEN),
		.RST_VAL ({L2_MASK_LEN{1'b1}})
	) u_l2_mask (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (msr_wr_i && hit_l2 && !wr_bad),
		.wr_idx_i  (tbl_idx),
		.wr_data_i (msr_wdata_i[L2_MASK_LEN-1:0]),
		.rd_idx_i  (tbl_idx),
		.rd_data_o (l2_rd),
		.a_idx_i   (l2_d_idx),
		.a_data_o  (l2_a),
		.b_idx_i   (l2_c_idx),
		.b_data_o  (l2_b)
	);

	// Throttles reset to zero delay, meaning no bandwidth enforcement.
	rdtq_class_table #(
		.W       (THRTL_W),
		.RST_VAL ('0)
	) u_throttle (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.wr_en_i   (msr_wr_i && hit_th && !wr_bad),
		.wr_idx_i  (tbl_idx),
		.wr_data_i (msr_wdata_i[THRTL_W-1:0]),
		.rd_idx_i  (tbl_idx),
		.rd_data_o (th_rd),
		.a_idx_i   (assoc_cls_q),
		.a_data_o  (th_a),
		.b_idx_i   (assoc_cls_q),
		.b_data_o  ()
	);

	// Cache-heavy threads get half the delay while under the threshold.
	assign th_reduced = (wc_en_q && l3_hit_heavy_i && (bw_usage_i <= bw_thr_q)) ?
	                    (th_a >> 1) : th_a;

	// The core shares one delay with its sibling; software picks which wins.
	assign th_resolved = res_max_q ?
	                     ((th_reduced > sibling_throttle_i) ? th_reduced : sibling_throttle_i) :
	                     ((th_reduced < sibling_throttle_i) ? th_reduced : sibling_throttle_i);

	// Applied settings are registered; a mask rewrite only moves capacity.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			service_class_o  <= '0;
			monitor_tag_id_o <= '0;
			l3_data_mask_o   <= '0;
			l3_code_mask_o   <= '0;
			l2_data_mask_o   <= '0;
			l2_code_mask_o   <= '0;
			throttle_o       <= '0;
		end else begin
			service_class_o  <= assoc_cls_q;
			monitor_tag_id_o <= assoc_tag_q;
			l3_data_mask_o   <= l3_a;
			l3_code_mask_o   <= l3_b;
			l2_data_mask_o   <= l2_a;
			l2_code_mask_o   <= l2_b;
			throttle_o       <= th_resolved;
		end
	end

	// Enable outputs straight from configuration flops.
	assign l3_code_data_split_o = qos_cfg_q[QCFG_L3_CDP_BIT];
	assign l2_code_data_split_o = qos_cfg_q[QCFG_L2_CDP_BIT];
	assign io_alloc_en_o        = io_qos_q[IOQ_ALLOC_BIT];
	assign io_mon_en_o          = io_qos_q[IOQ_MON_BIT];

	// Identification answers.
	rdtq_id_query u_id (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.req_i     (id_req_i),
		.leaf_i    (id_leaf_i),
		.subleaf_i (id_subleaf_i),
		.ack_o     (id_ack_o),
		.eax_o     (id_eax_o),
		.ebx_o     (id_ebx_o),
		.ecx_o     (id_ecx_o),
		.edx_o     (id_edx_o)
	);

endmodule : rdtq_alloc_regs

// file: src/rdtq_pkg.sv
// Purpose: Shared constants for the shared-resource allocation register bank.
// Assumes: Model-specific register space with 32-bit addresses and 64-bit data.
// Notes:   Every offset, field position, writable-bit mask and count lives here.
package rdtq_pkg;

	// Model-specific register addresses.
	localparam logic [31:0] ADDR_QOS_CFG      = 32'h0000_0c81;
	localparam logic [31:0] ADDR_IO_QOS       = 32'h0000_0c83;
	localparam logic [31:0] ADDR_BW_CFG       = 32'h0000_0c84;
	localparam logic [31:0] ADDR_ASSOC        = 32'h0000_0c8f;
	localparam logic [31:0] ADDR_L3_MASK_BASE = 32'h0000_0c90;
	localparam logic [31:0] ADDR_L2_MASK_BASE = 32'h0000_0d10;
	localparam logic [31:0] ADDR_THRTL_BASE   = 32'h0000_0d50;

	// Capability figures of this implementation.
	localparam int          NUM_CLASS   = 15;
	localparam int          NUM_CLASS_CDP = 7;
	localparam int          CLS_W       = 4;
	localparam int          L3_MASK_LEN = 12;
	localparam int          L2_MASK_LEN = 8;
	localparam int          THRTL_W     = 8;
	localparam int          BW_THR_W    = 16;
	localparam int          MON_TAG_W   = 10;
	localparam logic [7:0]  MAX_DELAY   = 8'h5a;
	localparam logic [7:0]  CNT_WIDTH   = 8'h20;
	localparam logic [7:0]  CNT_BASE    = 8'h18;
	localparam logic        SUP_L3      = 1'b1;
	localparam logic        SUP_L2      = 1'b1;
	localparam logic        SUP_BW      = 1'b1;

	// Field positions and writable-bit masks.
	localparam int          QCFG_L3_CDP_BIT = 0;
	localparam int          QCFG_L2_CDP_BIT = 1;
	localparam logic [63:0] QCFG_MASK       = 64'h0000_0000_0000_0003;
	localparam int          IOQ_ALLOC_BIT   = 0;
	localparam int          IOQ_MON_BIT     = 1;
	localparam logic [63:0] IOQ_MASK        = 64'h0000_0000_0000_0003;
	localparam int          BWC_RES_MAX_BIT = 16;
	localparam int          BWC_WC_EN_BIT   = 17;
	localparam logic [63:0] BWC_MASK        = 64'h0000_0000_0003_ffff;
	localparam int          ASSOC_CLS_LSB   = 32;
	localparam logic [63:0] ASSOC_MASK      = 64'h0000_000f_0000_03ff;

	// Identification query leaves and fields.
	localparam logic [31:0] LEAF_FEAT      = 32'h0000_0007;
	localparam logic [31:0] LEAF_MON       = 32'h0000_000f;
	localparam logic [31:0] LEAF_ALLOC     = 32'h0000_0010;
	localparam int          FEAT_ALLOC_BIT = 15;
	localparam int          CDP_ECX_BIT    = 2;
	localparam logic [31:0] RES_L3         = 32'h0000_0001;
	localparam logic [31:0] RES_L2         = 32'h0000_0002;
	localparam logic [31:0] RES_BW         = 32'h0000_0003;

endpackage : rdtq_pkg

// file: src/rdtq_class_table.sv
// Purpose: Per-class register array with one write port and three read ports.
// Assumes: Writers have already checked the index and the value.
// Notes:   Out-of-range read indices return zero.
module rdtq_class_table
	import rdtq_pkg::*;
#(
	parameter int         W     = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// Write port.
	input  wire logic             wr_en_i,
	input  wire logic [CLS_W-1:0] wr_idx_i,
	input  wire logic [W-1:0]     wr_data_i,
	// Read ports.
	input  wire logic [CLS_W-1:0] rd_idx_i,
	output logic      [W-1:0]     rd_data_o,
	input  wire logic [CLS_W-1:0] a_idx_i,
	output logic      [W-1:0]     a_data_o,
	input  wire logic [CLS_W-1:0] b_idx_i,
	output logic      [W-1:0]     b_data_o
);

	logic [W-1:0] entry_q [NUM_CLASS];

	// One flip-flop word per class, each loaded only by its own index.
	for (genvar i = 0; i < NUM_CLASS; i++) begin : g_entry
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				entry_q[i] <= RST_VAL;
			end else if (wr_en_i && (wr_idx_i == CLS_W'(i))) begin
				entry_q[i] <= wr_data_i;
			end
		end
	end

	// Index reads; the last index has no entry and reads zero.
	assign rd_data_o = (int'(rd_idx_i) < NUM_CLASS) ? entry_q[rd_idx_i] : '0;
	assign a_data_o  = (int'(a_idx_i) < NUM_CLASS) ? entry_q[a_idx_i] : '0;
	assign b_data_o  = (int'(b_idx_i) < NUM_CLASS) ? entry_q[b_idx_i] : '0;

endmodule : rdtq_class_table

// file: src/rdtq_id_query.sv
// Purpose: Answers processor identification queries about allocation support.
// Assumes: One query at a time; the answer follows one cycle later.
// Notes:   All answers are fixed capability figures from the package.
module rdtq_id_query
	import rdtq_pkg::*;
(
	// Clock and reset.
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Query.
	input  wire logic        req_i,
	input  wire logic [31:0] leaf_i,
	input  wire logic [31:0] subleaf_i,
	// Answer.
	output logic             ack_o,
	output logic      [31:0] eax_o,
	output logic      [31:0] ebx_o,
	output logic      [31:0] ecx_o,
	output logic      [31:0] edx_o
);

	logic [31:0] eax_d, ebx_d, ecx_d, edx_d;

	// Answer table; unknown leaves and sub-leaves read as zero.
	always_comb begin
		eax_d = '0;
		ebx_d = '0;
		ecx_d = '0;
		edx_d = '0;
		if (leaf_i == LEAF_FEAT && subleaf_i == '0) begin
			ebx_d[FEAT_ALLOC_BIT] = 1'b1;
		end else if (leaf_i == LEAF_MON && subleaf_i == 32'h0000_0001) begin
			eax_d[7:0] = CNT_WIDTH - CNT_BASE;
		end else if (leaf_i == LEAF_ALLOC) begin
			if (subleaf_i == '0) begin
				ebx_d[1] = SUP_L3;
				ebx_d[2] = SUP_L2;
				ebx_d[3] = SUP_BW;
			end else if (subleaf_i == RES_L3) begin
				eax_d[4:0]         = 5'(L3_MASK_LEN - 1);
				ecx_d[CDP_ECX_BIT] = 1'b1;
				edx_d[15:0]        = 16'(NUM_CLASS - 1);
			end else if (subleaf_i == RES_L2) begin
				eax_d[4:0]         = 5'(L2_MASK_LEN - 1);
				ecx_d[CDP_ECX_BIT] = 1'b1;
				edx_d[15:0]        = 16'(NUM_CLASS - 1);
			end else if (subleaf_i == RES_BW) begin
				eax_d[11:0] = 12'(MAX_DELAY) - 12'h001;
				edx_d[15:0] = 16'(NUM_CLASS - 1);
			end
		end
	end

	// Registered answer, one cycle after the query.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			eax_o <= '0;
			ebx_o <= '0;
			ecx_o <= '0;
			edx_o <= '0;
		end else begin
			ack_o <= req_i;
			eax_o <= eax_d;
			ebx_o <= ebx_d;
			ecx_o <= ecx_d;
			edx_o <= edx_d;
		end
	end

endmodule : rdtq_id_query

// file: dv/rdtq_alloc_regs_asserts.sv
// Purpose: Concurrent checks on the allocation register bank ports.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Legal writes are judged from the package masks, not from the bodies.
module rdtq_alloc_regs_asserts
	import rdtq_pkg::*;
(
	// Clock and reset.
	input wire logic             sys_clk_i,
	input wire logic             rst_i,
	// Register access.
	input wire logic             msr_rd_i,
	input wire logic             msr_wr_i,
	input wire logic [31:0]      msr_addr_i,
	input wire logic [63:0]      msr_wdata_i,
	input wire logic             msr_ack_o,
	input wire logic [63:0]      msr_rdata_o,
	input wire logic             protection_fault_zero_o,
	// Identification query.
	input wire logic             id_req_i,
	input wire logic [31:0]      id_leaf_i,
	input wire logic [31:0]      id_subleaf_i,
	input wire logic             id_ack_o,
	input wire logic [31:0]      id_ebx_o,
	// Applied settings and enables.
	input wire logic [CLS_W-1:0] service_class_o,
	input wire logic             io_alloc_en_o,
	input wire logic             l3_code_data_split_o,
	input wire logic             l2_code_data_split_o
);

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// A class below the split limit is legal whatever the split setting is.
	logic io_wr;
	logic as_ok;
	assign io_wr = msr_wr_i && msr_addr_i == ADDR_IO_QOS;
	assign as_ok = msr_wr_i && msr_addr_i == ADDR_ASSOC && (msr_wdata_i & ~ASSOC_MASK) == '0
		&& msr_wdata_i[35:32] < 4'h7;

	ack_after_req_a: assert property ((msr_rd_i || msr_wr_i) |=> msr_ack_o)
		else $error("register request not answered after one cycle");
	no_stray_ack_a: assert property (!(msr_rd_i || msr_wr_i) |=> !msr_ack_o)
		else $error("answer without a request");
	fault_with_ack_a: assert property (protection_fault_zero_o |-> msr_ack_o)
		else $error("fault raised outside an answer");
	fault_zero_data_a: assert property (protection_fault_zero_o |-> msr_rdata_o == '0)
		else $error("fault answer carries data");
	reserved_bit_fault_a: assert property (io_wr && (msr_wdata_i & ~IOQ_MASK) != '0
		|=> protection_fault_zero_o)
		else $error("reserved bit write not faulted");
	// The enable is a level from its flop, so it is judged one cycle on; a later
	// back-to-back write cannot disturb that sample.
	io_enable_set_a: assert property (io_wr && (msr_wdata_i & ~IOQ_MASK) == '0
		|=> io_alloc_en_o == $past(msr_wdata_i[IOQ_ALLOC_BIT]))
		else $error("I/O allocation enable does not follow its write");
	class_applied_a: assert property (as_ok
		|-> ##2 service_class_o == $past(msr_wdata_i[35:32], 2))
		else $error("service class not applied two cycles after write");
	split_off_reset_a: assert property ($fell(rst_i)
		|-> !l3_code_data_split_o && !l2_code_data_split_o)
		else $error("code/data split on after reset");
	alloc_flag_a: assert property (id_req_i && id_leaf_i == LEAF_FEAT
		&& id_subleaf_i == '0 |=> id_ack_o && id_ebx_o[FEAT_ALLOC_BIT])
		else $error("allocation support bit not reported");

endmodule : rdtq_alloc_regs_asserts

bind rdtq_alloc_regs rdtq_alloc_regs_asserts u_chk (.sys_clk_i, .rst_i, .msr_rd_i, .msr_wr_i,
	.msr_addr_i, .msr_wdata_i, .msr_ack_o, .msr_rdata_o, .protection_fault_zero_o, .id_req_i,
	.id_leaf_i, .id_subleaf_i, .id_ack_o, .id_ebx_o, .service_class_o, .io_alloc_en_o,
	.l3_code_data_split_o, .l2_code_data_split_o);

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the allocation register bank.
// Assumes: Answers come one cycle after each request, outputs one later.
// Notes:   Table rows cover register access; applied paths are hand tests.
module tb_top
	import rdtq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic        w;
		logic [31:0] a;
		logic [63:0] d;
		logic        f;
		logic [63:0] q;
	} rdtq_row_t;

	logic sys_clk_i = 1'b0, rst_i = 1'b1, msr_rd_i = 1'b0, msr_wr_i = 1'b0, id_req_i = 1'b0;
	logic [31:0] msr_addr_i = '0, id_leaf_i = '0, id_subleaf_i = '0;
	logic [63:0] msr_wdata_i = '0;
	logic l3_hit_heavy_i = 1'b0;
	logic [15:0] bw_usage_i = '0;
	logic [7:0] sibling_throttle_i = 8'h50;
	logic msr_ack_o, protection_fault_zero_o, id_ack_o, l3_code_data_split_o;
	logic l2_code_data_split_o, io_alloc_en_o, io_mon_en_o;
	logic [63:0] msr_rdata_o;
	logic [31:0] id_eax_o, id_ebx_o, id_ecx_o, id_edx_o;
	logic [3:0] service_class_o;
	logic [9:0] monitor_tag_id_o;
	logic [11:0] l3_data_mask_o, l3_code_mask_o;
	logic [7:0] l2_data_mask_o, l2_code_mask_o, throttle_o;
	int n_mismatch = 0;
	int cmp_count = 0;

	// Rows hold one access each, with the fault and data they should give.
	rdtq_row_t rows[20] = '{
		'{1'b0, ADDR_QOS_CFG, 64'h0, 1'b0, 64'h0}, '{1'b0, ADDR_L3_MASK_BASE, 64'h0, 1'b0, 64'hfff},
		'{1'b0, ADDR_L2_MASK_BASE, 64'h0, 1'b0, 64'hff}, '{1'b0, ADDR_THRTL_BASE, 64'h0, 1'b0, 64'h0},
		'{1'b0, ADDR_IO_QOS, 64'h0, 1'b0, 64'h0}, '{1'b1, ADDR_IO_QOS, 64'h3, 1'b0, 64'h0},
		'{1'b0, ADDR_IO_QOS, 64'h0, 1'b0, 64'h3}, '{1'b1, ADDR_IO_QOS, 64'h4, 1'b1, 64'h0},
		'{1'b0, 32'h0000_0c82, 64'h0, 1'b1, 64'h0},
		'{1'b1, ADDR_L3_MASK_BASE + 32'he, 64'h0f0, 1'b0, 64'h0},
		'{1'b0, ADDR_L3_MASK_BASE + 32'he, 64'h0, 1'b0, 64'h0f0},
		'{1'b1, ADDR_L3_MASK_BASE, 64'h1000, 1'b1, 64'h0},
		'{1'b0, ADDR_L3_MASK_BASE + 32'hf, 64'h0, 1'b1, 64'h0},
		'{1'b1, ADDR_THRTL_BASE + 32'h2, 64'h5a, 1'b0, 64'h0},
		'{1'b1, ADDR_THRTL_BASE + 32'h2, 64'h5b, 1'b1, 64'h0},
		'{1'b0, ADDR_THRTL_BASE + 32'h2, 64'h0, 1'b0, 64'h5a},
		'{1'b1, ADDR_ASSOC, 64'hf_0000_0000, 1'b1, 64'h0},
		'{1'b1, ADDR_ASSOC, 64'h3_0000_0005, 1'b0, 64'h0},
		'{1'b0, ADDR_ASSOC, 64'h0, 1'b0, 64'h3_0000_0005}, '{1'b0, ADDR_BW_CFG, 64'h0, 1'b0, 64'h0}};

	rdtq_alloc_regs dut (.*);

	// Clock at 25 MHz.
	initial begin
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : settle

	// One access; the strobe is raised for a single edge as the bus expects.
	task automatic msr(input logic w, input logic [31:0] a, input logic [63:0] d);
		@(posedge sys_clk_i);
		msr_wr_i <= w;
		msr_rd_i <= !w;
		msr_addr_i <= a;
		msr_wdata_i <= d;
		@(posedge sys_clk_i);
		msr_wr_i <= 1'b0;
		msr_rd_i <= 1'b0;
		#1;
		chk("ack", msr_ack_o, 64'h1);
	endtask : msr

	task automatic idq(input logic [31:0] l, input logic [31:0] s);
		@(posedge sys_clk_i);
		id_req_i <= 1'b1;
		id_leaf_i <= l;
		id_subleaf_i <= s;
		@(posedge sys_clk_i);
		id_req_i <= 1'b0;
		#1;
		chk("id_ack", id_ack_o, 64'h1);
	endtask : idq

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// Cuts a hang short well past the expected run of about a hundred cycles.
	initial begin
		#(5000 * 40);
		n_mismatch++;
		stop_test();
	end

	// Main sequence.
	initial begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		settle(2);
		chk("l3_mask", l3_data_mask_o, 64'hfff);
		chk("l3_split", l3_code_data_split_o, 64'h0);
		foreach (rows[i]) begin
			msr(rows[i].w, rows[i].a, rows[i].d);
			chk("fault", protection_fault_zero_o, rows[i].f);
			chk("rdata", msr_rdata_o, rows[i].q);
		end
		chk("io_en", {io_alloc_en_o, io_mon_en_o}, 64'h3);
		idq(LEAF_FEAT, 32'h0);
		chk("feat", id_ebx_o[FEAT_ALLOC_BIT], 64'h1);
		idq(LEAF_ALLOC, 32'h0);
		chk("res", id_ebx_o, 64'he);
		idq(LEAF_ALLOC, RES_L3);
		chk("l3_len", id_eax_o, L3_MASK_LEN - 1);
		chk("l3_cls", id_edx_o, NUM_CLASS - 1);
		chk("l3_cdp", id_ecx_o[CDP_ECX_BIT], 64'h1);
		idq(LEAF_ALLOC, RES_L2);
		chk("l2_len", id_eax_o, L2_MASK_LEN - 1);
		idq(LEAF_ALLOC, RES_BW);
		chk("bw_dly", id_eax_o, 64'h59);
		chk("bw_cls", id_edx_o, NUM_CLASS - 1);
		idq(LEAF_MON, 32'h1);
		chk("cnt_w", id_eax_o[7:0], 64'h08);
		msr(1'b1, ADDR_THRTL_BASE + 32'h3, 64'h40);
		msr(1'b1, ADDR_L3_MASK_BASE + 32'h3, 64'h00f);
		settle(2);
		chk("class", service_class_o, 64'h3);
		chk("tag", monitor_tag_id_o, 64'h5);
		chk("mask", l3_data_mask_o, 64'h00f);
		chk("thr_min", throttle_o, 64'h40);
		msr(1'b1, ADDR_BW_CFG, 64'h1_0000);
		settle(2);
		chk("thr_max", throttle_o, 64'h50);
		@(posedge sys_clk_i);
		sibling_throttle_i <= 8'h0;
		l3_hit_heavy_i <= 1'b1;
		bw_usage_i <= 16'h0080;
		msr(1'b1, ADDR_BW_CFG, 64'h3_0100);
		settle(2);
		chk("thr_wc", throttle_o, 64'h20);
		@(posedge sys_clk_i);
		bw_usage_i <= 16'h0200;
		settle(3);
		chk("thr_over", throttle_o, 64'h40);
		msr(1'b1, ADDR_QOS_CFG, 64'h1);
		msr(1'b1, ADDR_L3_MASK_BASE + 32'h6, 64'h0c0);
		msr(1'b1, ADDR_L3_MASK_BASE + 32'h7, 64'h300);
		settle(2);
		chk("split", {l3_code_data_split_o, l2_code_data_split_o}, 64'h2);
		chk("data", l3_data_mask_o, 64'h0c0);
		chk("code", l3_code_mask_o, 64'h300);
		msr(1'b1, ADDR_ASSOC, 64'h7_0000_0000);
		chk("cls7", protection_fault_zero_o, 64'h1);
		msr(1'b1, ADDR_QOS_CFG, 64'h3);
		msr(1'b1, ADDR_L2_MASK_BASE + 32'h6, 64'h0f);
		settle(2);
		chk("both", {l3_code_data_split_o, l2_code_data_split_o}, 64'h3);
		chk("l2_split", {l2_data_mask_o, l2_code_mask_o}, 64'h0fff);
		chk("kept", service_class_o, 64'h3);
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		settle(2);
		chk("rst", {l3_code_data_split_o, io_alloc_en_o, io_mon_en_o}, 64'h0);
		chk("rst_cls", service_class_o, 64'h0);
		stop_test();
	end

endmodule : tb_top
